//--- design/usb_xcvr_pkg.sv
// constants and carrier types for the usb transceiver and endpoint front end
package usb_xcvr_pkg;

  // register bus geometry
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_DATA_W = 32;

  // register byte offsets
  localparam logic [AXI_ADDR_W-1:0] XCVR_CTRL_OFS = 12'h000;
  localparam logic [AXI_ADDR_W-1:0] LINK_STATUS_OFS = 12'h004;
  localparam logic [AXI_ADDR_W-1:0] DROP_COUNT_OFS = 12'h008;
  localparam logic [AXI_ADDR_W-1:0] FRAME_LEN_OFS = 12'h00C;

  // transceiver control field positions
  localparam int PULLUP_EN_BIT = 7;
  localparam int XCVR_EN_BIT = 6;
  localparam int SPEED_FULL_BIT = 5;
  localparam int TEST_HI_BIT = 4;
  localparam int TEST_LO_BIT = 3;
  localparam int DIFF_RX_BIT = 2;
  localparam int DP_LEVEL_BIT = 1;
  localparam int DN_LEVEL_BIT = 0;
  localparam logic [4:0] XCVR_CTRL_RESET = 5'h00;

  // transceiver test modes
  localparam logic [1:0] TEST_NORMAL = 2'h0;
  localparam logic [1:0] TEST_DRIVE_J = 2'h1;
  localparam logic [1:0] TEST_DRIVE_K = 2'h2;
  localparam logic [1:0] TEST_DRIVE_SE0 = 2'h3;

  // endpoint addressing
  localparam int PIPE_COUNT = 8;
  localparam int EP_LAST = 3;
  localparam logic [7:0] EP_IN_FLAG = 8'h80;
  localparam logic [7:0] EP0_ADDR = 8'h00;

  // shared endpoint buffer
  localparam int FIFO_DEPTH = 1024;
  localparam logic [10:0] FIFO_FULL_COUNT = 11'h400;
  localparam logic [1:0] SKID_DEPTH = 2'h2;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one byte tagged with its pipe: pipe = {endpoint, direction is in}
  typedef struct packed {
    logic [2:0] pipe;
    logic [7:0] data;
  } pipe_word_t;

  // whole state of the front end
  typedef struct packed {
    logic [4:0] ctrl;
    logic aw_held;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_held;
    logic [AXI_DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [AXI_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic vbus_s1;
    logic vbus_s2;
    logic dp_s1;
    logic dp_s2;
    logic dn_s1;
    logic dn_s2;
    pipe_word_t [FIFO_DEPTH-1:0] mem;
    logic [9:0] wr_ptr;
    logic [9:0] rd_ptr;
    logic [10:0] count;
    pipe_word_t [1:0] skid;
    logic [1:0] skid_cnt;
    logic [15:0] drop_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] frame_len;
  } xcvr_state_t;

endpackage : usb_xcvr_pkg

//--- design/usb_function_xcvr_endpoint_cfg.sv
// usb function front end: transceiver control, pull-up placement, endpoint pipes
//
// Contract
// R1 - Exactly eight endpoint pipes exist across the control and data endpoints.
// R2 - The control endpoint is a two-way pipe answering on address 0x00 in both directions.
// R3 - Endpoints one to three are in/out pairs, in at 0x80 plus n and out at n.
// R4 - With speed select 1 the function runs full speed and the enabled pull-up sits on D+.
// R5 - With speed select 0 the function runs low speed and the enabled pull-up sits on D-.
// R6 - The pull-up is connected only while bus power is detected.
// R7 - The control register holds separate transceiver, pull-up and speed settings.
// R8 - The low five control bits serve transceiver testing, apart from enable and speed.
// R9 - Firmware should have the usb clock running before enabling the transceiver.
// R10 - The block is only a function and never takes the host role.
// R11 - A shared 1k byte buffer and frame-based clock recovery are included; the code only measures frame length in frame_len and trims no clock.
// R12 - The pull-up is driven only when enabled and powered, on the line speed selects.
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module usb_function_xcvr_endpoint_cfg
  import usb_xcvr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // axi4-lite write address
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [AXI_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [AXI_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // bus pins: power sense and data lines
  input wire logic vbus_in,
  input wire logic dp_in,
  output logic dp_out,
  output logic dp_oe,
  input wire logic dn_in,
  output logic dn_out,
  output logic dn_oe,
  // pull-up controls
  output logic dp_pullup,
  output logic dn_pullup,
  // transceiver controls
  output logic xcvr_enable,
  output logic speed_full,
  output logic [1:0] test_mode,
  // packets from the serial interface engine
  input wire logic rx_valid,
  input wire logic rx_in_dir,
  input wire logic [7:0] rx_ep_addr,
  input wire logic [7:0] rx_data,
  output logic rx_ready,
  input wire logic sof_pulse,
  // bytes toward the endpoint consumer
  output logic ep_valid,
  output pipe_word_t ep_word,
  input wire logic ep_ready
);

  xcvr_state_t q;
  xcvr_state_t n;

  // register window check, shared by read and write decode
  // word aligned and inside the first sixteen bytes
  function automatic logic reg_hit(input logic [AXI_ADDR_W-1:0] addr);
    reg_hit = (addr[AXI_ADDR_W-1:4] == '0) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // endpoint address to pipe number, valid flag in bit 3
  function automatic logic [3:0] pipe_of(input logic [7:0] addr, input logic in_dir);
    logic [1:0] ep;
    ep = addr[1:0];
    // no pipe unless a match below sets the flag
    pipe_of = 4'h0;
    // R2 control pipe both ways
    if (addr == EP0_ADDR) begin
      pipe_of = {1'b1, 2'h0, in_dir};
    // R3 paired data pipes
    end else if (ep != 2'h0 && addr[6:2] == 5'h00 && addr[7] == in_dir) begin
      pipe_of = {1'b1, ep, in_dir};
    end
  endfunction : pipe_of

  logic pull_on;
  logic [3:0] rx_pipe;
  logic rx_take;
  logic fifo_push;
  logic fifo_pop;
  logic skid_pop;
  logic [AXI_DATA_W-1:0] rd_value;
  logic wr_fire;
  logic wr_hit;
  logic ctrl_wr;
  logic rd_hit;
  logic line_diff;
  logic rx_drop;
  logic buf_empty;
  logic skid_full;

  // R7 separate control fields
  assign xcvr_enable = q.ctrl[XCVR_EN_BIT-3];
  assign speed_full = q.ctrl[SPEED_FULL_BIT-3];
  // R8 low control bits for testing
  assign test_mode = q.ctrl[TEST_HI_BIT-3:TEST_LO_BIT-3];

  // R6 pull-up needs bus power
  // R12 enable and power both required
  assign pull_on = q.ctrl[PULLUP_EN_BIT-3] & q.vbus_s2;
  // R4 full speed pulls D+
  assign dp_pullup = pull_on & speed_full;
  // R5 low speed pulls D-
  assign dn_pullup = pull_on & ~speed_full;

  // R8 test drive of the lines
  // R10 lines only driven under test, never as host
  always_comb begin
    // lines parked and released unless a test drives them
    dp_oe = 1'b0;
    dn_oe = 1'b0;
    dp_out = 1'b0;
    dn_out = 1'b0;
    if (xcvr_enable && test_mode != TEST_NORMAL) begin
      dp_oe = 1'b1;
      dn_oe = 1'b1;
      // J follows the idle polarity of the chosen speed
      case (test_mode)
        TEST_DRIVE_J: begin
          dp_out = speed_full;
          dn_out = ~speed_full;
        end
        TEST_DRIVE_K: begin
          dp_out = ~speed_full;
          dn_out = speed_full;
        end
        TEST_DRIVE_SE0: begin
          dp_out = 1'b0;
          dn_out = 1'b0;
        end
        default: begin
          dp_out = 1'b0;
          dn_out = 1'b0;
        end
      endcase
    end
  end

  // axi handshakes from state
  assign s_axi_awready = ~q.aw_held & ~q.bvalid;
  assign s_axi_wready = ~q.w_held & ~q.bvalid;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = ~q.rvalid;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = q.rdata;
  assign s_axi_rresp = q.rresp;

  // write completes once address and data are both held
  assign wr_fire = q.aw_held & q.w_held;
  assign wr_hit = reg_hit(q.aw_addr);
  // R7 only the low byte lane reaches the control fields
  assign ctrl_wr = wr_fire & wr_hit & (q.aw_addr[3:2] == XCVR_CTRL_OFS[3:2]) & q.w_strb[0];
  // reads outside the window answer an error with zero data
  assign rd_hit = reg_hit(s_axi_araddr);

  // R1 eight pipes decoded from the token
  assign rx_pipe = pipe_of(rx_ep_addr, rx_in_dir);
  // R11 shared buffer back-pressure
  assign rx_ready = (q.count != FIFO_FULL_COUNT);
  assign rx_take = rx_valid & rx_ready;
  assign fifo_push = rx_take & rx_pipe[3] & xcvr_enable;
  // unknown pipe or transceiver off: byte counted, not kept
  assign rx_drop = rx_take & ~fifo_push;

  // occupancy flags of buffer and stage
  assign buf_empty = (q.count == 11'h000);
  assign skid_full = (q.skid_cnt == SKID_DEPTH);

  // buffer head moves into the two-entry stage
  // a pop in the same cycle frees a slot, so a full stage still refills
  assign skid_pop = ep_valid & ep_ready;
  assign fifo_pop = ~buf_empty & (~skid_full | skid_pop);
  assign ep_valid = (q.skid_cnt != 2'h0);
  // stage head stands until the consumer takes it
  assign ep_word = q.skid[0];

  // differential receiver view of the synchronised lines
  assign line_diff = q.dp_s2 & ~q.dn_s2;

  // read data selection
  always_comb begin
    rd_value = '0;
    case (s_axi_araddr[3:2])
      XCVR_CTRL_OFS[3:2]: begin
        rd_value[7:3] = q.ctrl;
        rd_value[DIFF_RX_BIT] = line_diff;
        rd_value[DP_LEVEL_BIT] = q.dp_s2;
        rd_value[DN_LEVEL_BIT] = q.dn_s2;
      end
      LINK_STATUS_OFS[3:2]: begin
        rd_value[0] = q.vbus_s2;
        rd_value[1] = dp_pullup;
        rd_value[2] = dn_pullup;
        rd_value[18:8] = q.count;
      end
      DROP_COUNT_OFS[3:2]: begin
        rd_value[15:0] = q.drop_cnt;
      end
      FRAME_LEN_OFS[3:2]: begin
        rd_value[15:0] = q.frame_len;
      end
      default: begin
        rd_value = '0;
      end
    endcase
  end

  // next state
  always_comb begin
    n = q;

    // pin synchronisers, two stages each; only the second is read
    // bus power sense
    n.vbus_s1 = vbus_in;
    n.vbus_s2 = q.vbus_s1;
    // D+ line level
    n.dp_s1 = dp_in;
    n.dp_s2 = q.dp_s1;
    // D- line level
    n.dn_s1 = dn_in;
    n.dn_s2 = q.dn_s1;

    // write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_held = 1'b1;
      n.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_held = 1'b1;
      n.w_data = s_axi_wdata;
      n.w_strb = s_axi_wstrb;
    end
    // both halves held: answer in one step
    if (wr_fire) begin
      n.aw_held = 1'b0;
      n.w_held = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    // R7 control fields written together; read-only bits ignored
    if (ctrl_wr) begin
      n.ctrl = q.w_data[7:3];
    end
    // response stands until the master takes it
    if (q.bvalid && s_axi_bready) begin
      n.bvalid = 1'b0;
    end

    // read channel
    if (q.rvalid && s_axi_rready) begin
      n.rvalid = 1'b0;
    end
    // answer captured at the accepting edge
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rdata = rd_hit ? rd_value : '0;
      n.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end

    // bytes for unknown pipes or a disabled transceiver are counted and dropped
    if (rx_drop && q.drop_cnt != 16'hFFFF) begin // saturating
      n.drop_cnt = q.drop_cnt + 16'h0001;
    end

    // R11 shared buffer write and read
    if (fifo_push) begin
      n.mem[q.wr_ptr] = '{pipe: rx_pipe[2:0], data: rx_data};
      n.wr_ptr = q.wr_ptr + 10'h001;
    end
    if (fifo_pop) begin
      n.rd_ptr = q.rd_ptr + 10'h001;
    end
    // occupancy follows push and pop
    case ({fifo_push, fifo_pop})
      2'b10: n.count = q.count + 11'h001;
      2'b01: n.count = q.count - 11'h001;
      default: n.count = q.count;
    endcase

    // two-entry stage toward the consumer
    if (skid_pop) begin
      n.skid[0] = q.skid[1];
    end
    // head word lands behind what stays in the stage
    if (fifo_pop) begin
      if (skid_pop) begin
        n.skid[q.skid_cnt - 2'h1] = q.mem[q.rd_ptr];
      end else begin
        n.skid[q.skid_cnt[0]] = q.mem[q.rd_ptr];
      end
    end
    // stage occupancy
    case ({fifo_pop, skid_pop})
      2'b10: n.skid_cnt = q.skid_cnt + 2'h1;
      2'b01: n.skid_cnt = q.skid_cnt - 2'h1;
      default: n.skid_cnt = q.skid_cnt;
    endcase

    // R11 frame length for clock recovery trim
    // count saturates if frame starts stop
    if (sof_pulse) begin
      n.frame_len = q.frame_cnt;
      n.frame_cnt = 16'h0000;
    end else if (q.frame_cnt != 16'hFFFF) begin
      n.frame_cnt = q.frame_cnt + 16'h0001;
    end
  end

  // state register
  // reset clears everything; control takes its reset value
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl <= XCVR_CTRL_RESET;
    end else begin
      q <= n;
    end
  end

endmodule : usb_function_xcvr_endpoint_cfg

`default_nettype wire

//--- dv/usb_fe_chk.sv
// assertion checker for the usb transceiver front end
`timescale 1ns/10ps
`default_nettype none
module usb_fe_chk
  import usb_xcvr_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // register bus handshakes
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // power sense and pull-ups
  input wire logic vbus_in,
  input wire logic dp_pullup,
  input wire logic dn_pullup,
  input wire logic speed_full,
  // endpoint stream
  input wire logic ep_valid,
  input wire pipe_word_t ep_word,
  input wire logic ep_ready
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  property p_dp; dp_pullup |-> speed_full && !dn_pullup; endproperty
  a_dp: assert property (p_dp) else $error("pull-up on D+ at low speed");
  property p_dn; dn_pullup |-> !speed_full && !dp_pullup; endproperty
  a_dn: assert property (p_dn) else $error("pull-up on D- at full speed");
  property p_vbus; !vbus_in [*2] |=> !dp_pullup && !dn_pullup; endproperty
  a_vbus: assert property (p_vbus) else $error("pull-up without bus power");
  // write and read answers stand until taken; a read is answered the next cycle; no address is taken during a write response
  property p_b; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b: assert property (p_b) else $error("write response dropped");
  property p_r; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  a_r: assert property (p_r) else $error("read data dropped");
  property p_ar; s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid; endproperty
  a_ar: assert property (p_ar) else $error("read not answered next cycle");
  property p_aw; s_axi_bvalid |-> !s_axi_awready; endproperty
  a_aw: assert property (p_aw) else $error("address taken during response");
  // stalled word holds
  property p_ep; ep_valid && !ep_ready |=> ep_valid && $stable(ep_word); endproperty
  a_ep: assert property (p_ep) else $error("stalled endpoint word changed");
  // main scenarios reached
  c_dp: cover property (dp_pullup);
  c_dn: cover property (dn_pullup);
  c_stall: cover property (ep_valid && !ep_ready ##1 ep_valid && ep_ready);
endmodule : usb_fe_chk

bind usb_function_xcvr_endpoint_cfg usb_fe_chk u_chk (.clock(clock), .reset_n(reset_n),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .vbus_in(vbus_in), .dp_pullup(dp_pullup), .dn_pullup(dn_pullup), .speed_full(speed_full),
  .ep_valid(ep_valid), .ep_word(ep_word), .ep_ready(ep_ready));
`default_nettype wire

//--- dv/usb_host_model.sv
// host side of the usb cable: bus power and line levels
`timescale 1ns/10ps
`default_nettype none
module usb_host_model (
  // power switch from the bench
  input wire logic power_on,
  // device pin controls
  input wire logic dp_out,
  input wire logic dp_oe,
  input wire logic dn_out,
  input wire logic dn_oe,
  input wire logic dp_pullup,
  input wire logic dn_pullup,
  // levels seen by the device
  output logic vbus_in,
  output logic dp_line,
  output logic dn_line
);
  // host pull-downs lose to the device pull-up or driver
  assign vbus_in = power_on;
  assign dp_line = dp_oe ? dp_out : dp_pullup;
  assign dn_line = dn_oe ? dn_out : dn_pullup;
endmodule : usb_host_model
`default_nettype wire

//--- dv/usb_function_xcvr_endpoint_cfg_tb.sv
// self-checking bench for the usb transceiver front end
`timescale 1ns/10ps
`default_nettype none
module usb_function_xcvr_endpoint_cfg_tb;
  import usb_xcvr_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, power_on = 1'b0, ep_ready = 1'b0, sof_pulse = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rx_valid = 1'b0, rx_in_dir = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = '0;
  logic [7:0] rx_ep_addr = '0, rx_data = '0;
  logic [1:0] s_axi_bresp, s_axi_rresp, test_mode, rr;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, vbus_in;
  logic dp_in, dp_out, dp_oe, dn_in, dn_out, dn_oe, dp_pullup, dn_pullup, rx_ready, ep_valid;
  logic xcvr_enable, speed_full;
  pipe_word_t ep_word;
  pipe_word_t exp_q[$];
  int errors = 0, n_tests = 0;

  usb_function_xcvr_endpoint_cfg dut (.clock, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vbus_in, .dp_in, .dp_out, .dp_oe, .dn_in,
    .dn_out, .dn_oe, .dp_pullup, .dn_pullup, .xcvr_enable, .speed_full, .test_mode, .rx_valid,
    .rx_in_dir, .rx_ep_addr, .rx_data, .rx_ready, .sof_pulse, .ep_valid, .ep_word,
    .ep_ready);
  usb_host_model host (.power_on, .dp_out, .dp_oe, .dn_out, .dn_oe, .dp_pullup, .dn_pullup,
    .vbus_in, .dp_line(dp_in), .dn_line(dn_in));

  always #20 clock = ~clock;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : conclude

  // control write, expects an okay answer
  task automatic wr(input logic [7:0] d);
    logic ta, tw, done;
    done = 1'b0;
    @(posedge clock);
    s_axi_awaddr <= XCVR_CTRL_OFS;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    check(rr, RESP_OKAY);
  endtask : wr

  task automatic rd_reg(input logic [11:0] a);
    logic ta, done;
    done = 1'b0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(negedge clock);
      ta = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rx_send(input logic [7:0] a, input logic dir, input logic [7:0] d);
    logic done;
    done = 1'b0;
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_ep_addr <= a;
    rx_in_dir <= dir;
    rx_data <= d;
    while (!done) begin
      @(negedge clock);
      done = rx_ready;
      @(posedge clock);
    end
    rx_valid <= 1'b0;
  endtask : rx_send

  // releases the stalled consumer and compares every word in order
  task automatic drain();
    int i;
    i = 0;
    @(posedge clock);
    ep_ready <= 1'b1;
    repeat (exp_q.size() + 8) begin
      @(negedge clock);
      if (ep_valid && i < exp_q.size()) check(ep_word, exp_q[i]);
      if (ep_valid) i++;
      @(posedge clock);
    end
    ep_ready <= 1'b0;
    check(i, exp_q.size());
    exp_q.delete();
  endtask : drain

  task automatic t_regs();
    rd_reg(XCVR_CTRL_OFS);
    check(rd[7:3], XCVR_CTRL_RESET);
    check(rr, RESP_OKAY);
    wr(8'hE0);
    rd_reg(XCVR_CTRL_OFS);
    check({rd[7:3], xcvr_enable, speed_full, dp_pullup}, 8'hE6);
    rd_reg(12'h010);
    check(rr, RESP_SLVERR);
    check(rd, 32'h00000000);
  endtask : t_regs

  task automatic t_pullup();
    power_on <= 1'b1;
    repeat (3) @(posedge clock);
    check({dp_pullup, dn_pullup, dp_in}, 3'h5);
    rd_reg(LINK_STATUS_OFS);
    check(rd, 32'h00000003);
    rd_reg(XCVR_CTRL_OFS);
    check(rd, 32'h000000E6);
    wr(8'hC0);
    check({dp_pullup, dn_pullup, dn_in}, 3'h3);
    wr(8'h40);
    check({dp_pullup, dn_pullup}, 2'h0);
    wr(8'hC0);
    power_on <= 1'b0;
    repeat (3) @(posedge clock);
    check({dp_pullup, dn_pullup}, 2'h0);
  endtask : t_pullup

  task automatic t_test();
    // test mode with the transceiver off drives nothing
    wr(8'h18);
    check({dp_oe, dn_oe}, 2'h0);
    for (int m = 0; m < 4; m++) begin
      wr(8'h60 | 8'(m << 3));
      check({test_mode, dp_oe, dn_oe, dp_out, dn_out}, {2'(m), {2{m != 0}}, m == 1, m == 2});
    end
  endtask : t_test

  task automatic t_pipes();
    logic [7:0] ad[10] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83, 8'h84, 8'h81};
    logic dr[10] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_send(ad[i], dr[i], 8'hA0 + 8'(i));
      if (i < 8) exp_q.push_back({ad[i][1:0], dr[i], 8'hA0 + 8'(i)});
    end
    drain();
    rd_reg(DROP_COUNT_OFS);
    check(rd, 32'h00000002);
  endtask : t_pipes

  // two frame starts a hundred clocks apart
  task automatic t_frame();
    repeat (2) begin
      @(posedge clock);
      sof_pulse <= 1'b1;
      @(posedge clock);
      sof_pulse <= 1'b0;
      repeat (98) @(posedge clock);
    end
    rd_reg(FRAME_LEN_OFS);
    check(rd, 32'h00000063);
  endtask : t_frame

  task automatic t_fill();
    logic done;
    done = 1'b0;
    @(posedge clock);
    rx_valid <= 1'b1;
    rx_ep_addr <= 8'h01;
    rx_in_dir <= 1'b0;
    rx_data <= 8'h00;
    while (!done) begin
      @(negedge clock);
      done = !rx_ready;
      if (rx_ready) exp_q.push_back({3'h2, rx_data});
      @(posedge clock);
      rx_data <= 8'(exp_q.size());
    end
    rx_valid <= 1'b0;
    // buffer plus two-entry stage absorb the stalled stream
    check(exp_q.size(), FIFO_DEPTH + 2);
    rd_reg(LINK_STATUS_OFS);
    check(rd, 32'h00040000);
    drain();
  endtask : t_fill

  // main sequence after four reset cycles
  initial begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    t_regs();
    t_pullup();
    t_test();
    t_pipes();
    t_frame();
    t_fill();
    conclude();
  end

  // watchdog against a hang
  initial begin
    repeat (12000) @(posedge clock);
    errors++;
    conclude();
  end
endmodule : usb_function_xcvr_endpoint_cfg_tb
`default_nettype wire
